// >>> mmc_top.sv
// Memory map control: position registers, Avalon-MM slave and registered map decode
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module mmc_top #(
    parameter int unsigned RAM_AW = 11,
    parameter logic [7:0] MEMSIZE_A = 8'h10,
    parameter logic [7:0] MEMSIZE_B = 8'h00,
    parameter logic EE_BASE_ONCE = 1'b0,
    parameter logic [5:0] FIXED_PAGE_LOW = 6'h3E,
    parameter logic [5:0] FIXED_PAGE_HIGH = 6'h3F
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [2:0] mode_pins,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_valid,
    input wire logic [15:0] cpu_addr,
    output logic sel_reg_q,
    output logic sel_ram_q,
    output logic sel_ee_q,
    output logic sel_flash_q,
    output logic sel_ext_q,
    output logic [5:0] flash_page_q,
    output logic [1:0] external_access_stretch_q,
    output logic emulation_select_n_q,
    output logic external_select_n_q
);
    // ==========================================================
    // Mode pins synchroniser
    logic [2:0] mode_meta_q;
    logic [2:0] mode_sync_q;
    logic [1:0] settle_q;
    logic mode_ok_q;

    // Mode pins come from outside; two stages before anything looks at them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_meta_q <= 3'h0;
            mode_sync_q <= 3'h0;
        end else begin
            mode_meta_q <= mode_pins;
            mode_sync_q <= mode_meta_q;
        end
    end

    // Hold off mode-dependent setup until the synchroniser holds real pin values
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 2'h0;
            mode_ok_q <= 1'b0;
        end else begin
            settle_q <= (settle_q == mmc_pkg::MODE_SETTLE) ? settle_q : settle_q + 2'h1;
            mode_ok_q <= (settle_q == mmc_pkg::MODE_SETTLE);
        end
    end

    // ==========================================================
    // Mode classification
    mmc_pkg::mmc_mode_t mode;
    assign mode = mmc_pkg::mmc_mode_t'(mode_sync_q);
    // Emulation modes lock like normal modes; only true special modes rewrite freely
    wire is_special = (mode == mmc_pkg::MODE_SPECIAL_SINGLE) || (mode == mmc_pkg::MODE_SPECIAL_TEST)
                      || (mode == mmc_pkg::MODE_PERIPHERAL);
    wire is_emul = (mode == mmc_pkg::MODE_EMUL_NARROW) || (mode == mmc_pkg::MODE_EMUL_WIDE);
    wire is_single = (mode == mmc_pkg::MODE_SPECIAL_SINGLE) || (mode == mmc_pkg::MODE_NORMAL_SINGLE)
                     || (mode == mmc_pkg::MODE_PERIPHERAL);
    wire is_test = mode == mmc_pkg::MODE_SPECIAL_TEST;
    wire ext_ok = !is_single;

    // ==========================================================
    // Avalon-MM slave handshake
    logic wait_q;
    logic [31:0] rdata_q;
    logic init_done_q;

    wire [5:0] idx = avs_address[7:2];
    wire req = avs_read || avs_write;
    wire accept = req && wait_q;
    wire wr_take = avs_write && !wait_q && avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];

    // Waitrequest drops for one cycle, one cycle after a request appears
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !accept;
        end
    end

    // ==========================================================
    // Register write strobes
    wire wr_ram = wr_take && (idx == mmc_pkg::IDX_RAM_POS);
    wire wr_reg = wr_take && (idx == mmc_pkg::IDX_REG_POS);
    wire wr_ee = wr_take && (idx == mmc_pkg::IDX_EE_POS);
    wire wr_misc = wr_take && (idx == mmc_pkg::IDX_MISC);
    wire wr_page = wr_take && (idx == mmc_pkg::IDX_PAGE);

    // ==========================================================
    // Position and control registers
    logic [7:0] ram_pos_q;
    logic [7:0] reg_pos_q;
    logic [7:0] ee_pos_q;
    logic [7:0] misc_q;
    logic [7:0] page_q;
    logic ram_lock_q;
    logic reg_lock_q;
    logic ee_lock_q;
    logic misc_lock_q;

    // Special modes may rewrite at any time; normal and emulation only once, the EE base only when EE_BASE_ONCE is set
    wire ram_open = is_special || !ram_lock_q;
    wire reg_open = is_special || !reg_lock_q;
    wire ee_open = is_special || !EE_BASE_ONCE || !ee_lock_q;
    wire misc_open = is_special || !misc_lock_q;

    wire [7:0] ram_pos_d = (wr_ram && ram_open) ? (wbyte & mmc_pkg::RAM_POS_MASK) : ram_pos_q;
    wire [7:0] reg_pos_d = (wr_reg && reg_open) ? (wbyte & mmc_pkg::REG_POS_MASK) : reg_pos_q;
    wire [7:0] ee_base_d = ee_open ? (wbyte & mmc_pkg::EE_BASE_MASK) : (ee_pos_q & mmc_pkg::EE_BASE_MASK);
    wire [7:0] ee_pos_d = wr_ee ? (ee_base_d | (wbyte & mmc_pkg::EE_ON_MASK)) : ee_pos_q;
    wire [7:0] page_d = wr_page ? (wbyte & mmc_pkg::PAGE_MASK) : page_q;

    // The flash-on reset value depends on mode, so it is fixed up after release
    wire misc_init = mode_ok_q && !init_done_q && is_test;
    wire [7:0] misc_w = (wr_misc && misc_open) ? (wbyte & mmc_pkg::MISC_MASK) : misc_q;
    wire [7:0] misc_d = misc_init ? mmc_pkg::RST_MISC_TEST : misc_w;

    // Position registers; writes land here, decode sees them on the next edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ram_pos_q <= mmc_pkg::RST_RAM_POS;
            reg_pos_q <= mmc_pkg::RST_REG_POS;
            ee_pos_q <= mmc_pkg::RST_EE_POS;
            misc_q <= mmc_pkg::RST_MISC;
            page_q <= mmc_pkg::RST_PAGE;
        end else begin
            ram_pos_q <= ram_pos_d;
            reg_pos_q <= reg_pos_d;
            ee_pos_q <= ee_pos_d;
            misc_q <= misc_d;
            page_q <= page_d;
        end
    end

    // Lock flags record the first write after reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ram_lock_q <= 1'b0;
            reg_lock_q <= 1'b0;
            ee_lock_q <= 1'b0;
            misc_lock_q <= 1'b0;
            init_done_q <= 1'b0;
        end else begin
            ram_lock_q <= ram_lock_q || wr_ram;
            reg_lock_q <= reg_lock_q || wr_reg;
            ee_lock_q <= ee_lock_q || wr_ee;
            misc_lock_q <= misc_lock_q || wr_misc;
            init_done_q <= init_done_q || mode_ok_q;
        end
    end

    // ==========================================================
    // Read multiplexer
    logic [7:0] rmux;

    // Unlisted, test and reserved slots return zero so software sees no stale data
    always_comb begin
        unique case (idx)
            mmc_pkg::IDX_RAM_POS: rmux = ram_pos_q;
            mmc_pkg::IDX_REG_POS: rmux = reg_pos_q;
            mmc_pkg::IDX_EE_POS: rmux = ee_pos_q;
            mmc_pkg::IDX_MISC: rmux = misc_q;
            mmc_pkg::IDX_MEMSIZE_A: rmux = MEMSIZE_A;
            mmc_pkg::IDX_MEMSIZE_B: rmux = MEMSIZE_B;
            mmc_pkg::IDX_PAGE: rmux = page_q;
            default: rmux = 8'h00;
        endcase
    end

    // Read data is captured with the accept and stands while waitrequest is low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (accept && avs_read) begin
            rdata_q <= {24'h00_0000, rmux};
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // ==========================================================
    // Address decode from the stored positions
    logic hit_reg;
    logic hit_ram;
    logic hit_ee;
    logic hit_flash;
    logic hit_ext;

    mmc_decode #(
        .RAM_AW(RAM_AW),
        .MEMSIZE_A(MEMSIZE_A)
    ) u_decode (
        .addr(cpu_addr),
        .ram_pos(ram_pos_q),
        .reg_pos(reg_pos_q),
        .ee_pos(ee_pos_q),
        .misc(misc_q),
        .ext_ok(ext_ok),
        .hit_reg(hit_reg),
        .hit_ram(hit_ram),
        .hit_ee(hit_ee),
        .hit_flash(hit_flash),
        .hit_ext(hit_ext)
    );

    // Page for flash: window takes the page index, fixed quarters their own pages
    wire [5:0] page_sel = (cpu_addr[15:14] == mmc_pkg::QUAD_WINDOW) ? page_q[5:0]
                        : (cpu_addr[15:14] == mmc_pkg::QUAD_FIXED_LOW) ? FIXED_PAGE_LOW
                        : FIXED_PAGE_HIGH;

    // Emulation select replaces internal flash when running in an emulation mode
    wire emul_d = cpu_valid && hit_flash && is_emul;
    wire ext_d = cpu_valid && hit_ext;
    wire [1:0] stretch_d = ext_d ? misc_q[mmc_pkg::STRETCH_LSB +: 2] : 2'h0;

    // Selects are registered, so they follow the address presented one cycle before
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_reg_q <= 1'b0;
            sel_ram_q <= 1'b0;
            sel_ee_q <= 1'b0;
            sel_flash_q <= 1'b0;
            sel_ext_q <= 1'b0;
            flash_page_q <= 6'h00;
            external_access_stretch_q <= 2'h0;
            emulation_select_n_q <= 1'b1;
            external_select_n_q <= 1'b1;
        end else begin
            sel_reg_q <= cpu_valid && hit_reg;
            sel_ram_q <= cpu_valid && hit_ram;
            sel_ee_q <= cpu_valid && hit_ee;
            sel_flash_q <= cpu_valid && hit_flash && !is_emul;
            sel_ext_q <= ext_d;
            flash_page_q <= page_sel;
            external_access_stretch_q <= stretch_d;
            emulation_select_n_q <= !emul_d;
            external_select_n_q <= !ext_d;
        end
    end
endmodule

// >>> mmc_pkg.sv
// Shared constants, register map and mode codes for the memory map control block
package mmc_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam int unsigned IDX_W = 6;
    localparam logic [5:0] IDX_RAM_POS = 6'h10;
    localparam logic [5:0] IDX_REG_POS = 6'h11;
    localparam logic [5:0] IDX_EE_POS = 6'h12;
    localparam logic [5:0] IDX_MISC = 6'h13;
    localparam logic [5:0] IDX_TEST_A = 6'h14;
    localparam logic [5:0] IDX_TEST_B = 6'h17;
    localparam logic [5:0] IDX_MEMSIZE_A = 6'h1C;
    localparam logic [5:0] IDX_MEMSIZE_B = 6'h1D;
    localparam logic [5:0] IDX_PAGE = 6'h30;
    localparam logic [5:0] IDX_PAGE_RSVD = 6'h31;

    // ==========================================================
    // Implemented-bit masks; all other bits read as zero
    localparam logic [7:0] RAM_POS_MASK = 8'hF9;
    localparam logic [7:0] REG_POS_MASK = 8'h78;
    localparam logic [7:0] EE_BASE_MASK = 8'hF8;
    localparam logic [7:0] EE_ON_MASK = 8'h01;
    localparam logic [7:0] MISC_MASK = 8'h0F;
    localparam logic [7:0] PAGE_MASK = 8'h3F;

    // ==========================================================
    // Field positions
    localparam int unsigned RAM_HIGH_ALIGN_BIT = 0;
    localparam int unsigned EE_ON_BIT = 0;
    localparam int unsigned FLASH_ON_BIT = 0;
    localparam int unsigned FLASH_UPPER_BIT = 1;
    localparam int unsigned STRETCH_LSB = 2;
    localparam int unsigned BASE_LSB = 3;
    localparam int unsigned REGION_SHIFT = 11;
    localparam int unsigned MEMSIZE_REG_BIT = 7;
    localparam int unsigned MEMSIZE_EE_LSB = 4;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_RAM_POS = 8'h00;
    localparam logic [7:0] RST_REG_POS = 8'h00;
    localparam logic [7:0] RST_EE_POS = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h0D;
    localparam logic [7:0] RST_MISC_TEST = 8'h0C;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [1:0] MODE_SETTLE = 2'h3;

    // ==========================================================
    // Flash quarters of the 64K map
    localparam logic [1:0] QUAD_BOTTOM = 2'h0;
    localparam logic [1:0] QUAD_FIXED_LOW = 2'h1;
    localparam logic [1:0] QUAD_WINDOW = 2'h2;

    // ==========================================================
    // Operating modes as presented on the mode pins
    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE = 3'b000,
        MODE_EMUL_NARROW = 3'b001,
        MODE_SPECIAL_TEST = 3'b010,
        MODE_EMUL_WIDE = 3'b011,
        MODE_NORMAL_SINGLE = 3'b100,
        MODE_NORMAL_NARROW = 3'b101,
        MODE_PERIPHERAL = 3'b110,
        MODE_NORMAL_WIDE = 3'b111
    } mmc_mode_t;

endpackage

// >>> mmc_decode.sv
// Combinational address decoder that picks one resource from the position registers
`timescale 1ns/1ps
module mmc_decode #(
    parameter int unsigned RAM_AW = 11,
    parameter logic [7:0] MEMSIZE_A = 8'h10
) (
    input wire logic [15:0] addr,
    input wire logic [7:0] ram_pos,
    input wire logic [7:0] reg_pos,
    input wire logic [7:0] ee_pos,
    input wire logic [7:0] misc,
    input wire logic ext_ok,
    output logic hit_reg,
    output logic hit_ram,
    output logic hit_ee,
    output logic hit_flash,
    output logic hit_ext
);
    // ==========================================================
    // Geometry fixed at integration
    localparam int unsigned MAP_AW = (RAM_AW > 11) ? RAM_AW : 11;
    localparam logic [15:0] MAP_MASK = 16'(32'hFFFF << MAP_AW);
    localparam logic [15:0] RAM_SIZE = 16'(32'h1 << RAM_AW);
    localparam logic [15:0] MAP_SIZE_M1 = ~MAP_MASK;
    localparam logic [1:0] EE_SW = MEMSIZE_A[mmc_pkg::MEMSIZE_EE_LSB +: 2];
    localparam int unsigned EE_AW = 10 + EE_SW;
    localparam logic [15:0] EE_MASK = 16'(32'hFFFF << EE_AW);
    localparam logic REG_2K = MEMSIZE_A[mmc_pkg::MEMSIZE_REG_BIT];

    if (RAM_AW < 10 || RAM_AW > 15) begin : g_bad_ram
        $error("RAM_AW must lie in 10..15");
    end

    // Region bases from the upper five address bits of the RAM and EEPROM positions, four of the register position
    wire [15:0] ram_base = {ram_pos[7:3], 11'h000};
    wire [4:0] reg_base = {1'b0, reg_pos[6:3]};
    wire [15:0] ee_base = {ee_pos[7:3], 11'h000};

    // Register block: 1K or 2K window on a 2K boundary below 32K
    wire reg_in = (addr[15:11] == reg_base) && (REG_2K || !addr[10]);

    // RAM sits at the low or the high end of its mappable block
    wire [15:0] ram_off = addr & MAP_SIZE_M1;
    wire ram_blk = (addr & MAP_MASK) == (ram_base & MAP_MASK);
    wire ram_lo = ram_off < RAM_SIZE;
    // Start of the top-aligned slot; wraps to zero when the RAM fills its whole block
    wire ram_hi = ram_off >= (MAP_SIZE_M1 - RAM_SIZE + 16'h0001);
    wire ram_in = ram_blk && (ram_pos[mmc_pkg::RAM_HIGH_ALIGN_BIT] ? ram_hi : ram_lo);

    // EEPROM only when fitted and enabled
    wire ee_in = (EE_SW != 2'h0) && ee_pos[mmc_pkg::EE_ON_BIT]
                 && ((addr & EE_MASK) == (ee_base & EE_MASK));

    // Flash covers the top three quarters; the fixed low quarter can be hidden
    wire fl_quad = addr[15:14] != mmc_pkg::QUAD_BOTTOM;
    wire fl_hide = misc[mmc_pkg::FLASH_UPPER_BIT] && (addr[15:14] == mmc_pkg::QUAD_FIXED_LOW);
    wire fl_in = misc[mmc_pkg::FLASH_ON_BIT] && fl_quad && !fl_hide;

    // Fixed priority so exactly one resource answers an overlap
    assign hit_reg = reg_in;
    assign hit_ram = ram_in && !reg_in;
    assign hit_ee = ee_in && !reg_in && !ram_in;
    assign hit_flash = fl_in && !reg_in && !ram_in && !ee_in;
    assign hit_ext = ext_ok && !reg_in && !ram_in && !ee_in && !fl_in;
endmodule

// >>> mmc_asserts.sv
// Port-level concurrent checks for the memory map control block
`timescale 1ns/1ps
module mmc_asserts #(
    parameter logic [5:0] FIXED_PAGE_LOW = 6'h3E
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [2:0] mode_pins,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_valid,
    input wire logic [15:0] cpu_addr,
    input wire logic sel_reg_q,
    input wire logic sel_ram_q,
    input wire logic sel_ee_q,
    input wire logic sel_flash_q,
    input wire logic sel_ext_q,
    input wire logic [5:0] flash_page_q,
    input wire logic [1:0] external_access_stretch_q,
    input wire logic emulation_select_n_q,
    input wire logic external_select_n_q
);
    // ==========================================================
    // Grouped selects, one clock domain
    wire logic [4:0] sel_all = {sel_reg_q, sel_ram_q, sel_ee_q, sel_flash_q, sel_ext_q};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_IDLE_QUIET: assert property (!cpu_valid |=> sel_all == 5'h00 && emulation_select_n_q)
        else $error("Select active without a valid address");
    AST_ONE_SELECT: assert property ($onehot0(sel_all))
        else $error("More than one resource selected");
    AST_REG_LOW_HALF: assert property (cpu_valid && cpu_addr[15] |=> !sel_reg_q)
        else $error("Register block selected above 32K");
    AST_XCS_TRACKS: assert property (external_select_n_q == !sel_ext_q)
        else $error("External select disagrees with external hit");
    AST_STRETCH_IDLE: assert property (external_select_n_q |-> external_access_stretch_q == 2'h0)
        else $error("Stretch reported outside external access");
    AST_ECS_ALONE: assert property (!emulation_select_n_q |-> !sel_flash_q && !sel_ext_q)
        else $error("Emulation select with flash or external select");
    AST_SINGLE_NO_EXT: assert property ((mode_pins == 3'b000) [*6] |=> external_select_n_q)
        else $error("External select in single chip mode");
    AST_PAGE_LOW: assert property (cpu_addr[15:14] == 2'h1 |=> flash_page_q == FIXED_PAGE_LOW)
        else $error("Wrong page for lower fixed window");
    AST_RD_TOP_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("Read data upper bits not zero");
endmodule

bind mmc_top mmc_asserts #(.FIXED_PAGE_LOW(FIXED_PAGE_LOW)) u_asserts (.sys_clk(sys_clk), .rstn(rstn),
    .mode_pins(mode_pins), .avs_read(avs_read), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .sel_reg_q(sel_reg_q),
    .sel_ram_q(sel_ram_q), .sel_ee_q(sel_ee_q), .sel_flash_q(sel_flash_q), .sel_ext_q(sel_ext_q),
    .flash_page_q(flash_page_q), .external_access_stretch_q(external_access_stretch_q),
    .emulation_select_n_q(emulation_select_n_q), .external_select_n_q(external_select_n_q));

// >>> mmc_cpu_model.sv
// Behavioural core-side address source for the decoder
`timescale 1ns/1ps
module mmc_cpu_model (
    input wire logic sys_clk,
    input wire logic req,
    input wire logic [15:0] req_addr,
    output logic cpu_valid,
    output logic [15:0] cpu_addr
);
    logic [15:0] junk_q;
    // Idle address churns so a stale value never looks live
    initial junk_q = 16'hA5A5;
    always @(posedge sys_clk) begin
        junk_q <= ~junk_q ^ 16'h0001;
    end
    assign cpu_valid = req;
    assign cpu_addr = req ? req_addr : junk_q;
endmodule

// >>> tb_top.sv
// Self-checking bench for the memory map control block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest, cpu_valid, req;
    logic [2:0] mode_pins, s_mode;
    logic [7:0] avs_address, s_ram, s_reg, s_ee, s_misc, s_page;
    logic [31:0] avs_writedata, avs_readdata, rnd, rd;
    logic [3:0] avs_byteenable;
    logic [15:0] cpu_addr, req_addr;
    logic sel_reg_q, sel_ram_q, sel_ee_q, sel_flash_q, sel_ext_q, ecs_n, xcs_n;
    logic [5:0] flash_page_q;
    logic [1:0] stretch;
    int error_cnt, checked;
    logic [15:0] corner [16] = '{16'h0000, 16'h03FF, 16'h0400, 16'h4BFF, 16'h4C00, 16'h4FFF, 16'h5000,
        16'h57FF, 16'h7800, 16'h7BFF, 16'h7C00, 16'h8000, 16'h8800, 16'h8FFF, 16'hC000, 16'hFFFF};

    // ==========================================================
    // Design and core model; RAM smaller than its block to expose alignment
    mmc_top #(.RAM_AW(10)) DUT (.sys_clk(sys_clk), .rstn(rstn), .mode_pins(mode_pins),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
        .sel_reg_q(sel_reg_q), .sel_ram_q(sel_ram_q), .sel_ee_q(sel_ee_q), .sel_flash_q(sel_flash_q),
        .sel_ext_q(sel_ext_q), .flash_page_q(flash_page_q), .external_access_stretch_q(stretch),
        .emulation_select_n_q(ecs_n), .external_select_n_q(xcs_n));
    mmc_cpu_model u_cpu (.sys_clk(sys_clk), .req(req), .req_addr(req_addr), .cpu_valid(cpu_valid),
        .cpu_addr(cpu_addr));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected selects, strobes, stretch and page for one address
    function automatic logic [14:0] exp_dec(input logic [15:0] a);
        logic r, m, e, f, x, emu;
        logic [5:0] pg;
        r = a[15:11] == {1'b0, s_reg[6:3]} && !a[10];
        m = !r && a[15:11] == s_ram[7:3] && a[10] == s_ram[0];
        e = !r && !m && a[15:11] == s_ee[7:3] && s_ee[0];
        f = !r && !m && !e && s_misc[0] && a >= 16'h4000 && !(s_misc[1] && !a[15]);
        x = !r && !m && !e && !f && !(s_mode inside {3'b000, 3'b100, 3'b110});
        emu = f && (s_mode inside {3'b001, 3'b011});
        pg = a[15:14] == 2'h2 ? s_page[5:0] : (a[15:14] == 2'h1 ? 6'h3E : 6'h3F);
        return {r, m, e, f && !emu, x, !emu, !x, x ? s_misc[3:2] : 2'h0, pg};
    endfunction

    task automatic final_report();
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            final_report();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, i, d, 4'h1);
    endtask

    task automatic rchk(input string n, input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00, 4'h1);
        chk(n, {24'h0, e}, rd);
    endtask

    // Address held one edge, outputs compared after the next
    task automatic probe(input logic [15:0] a);
        @(posedge sys_clk);
        req <= 1'b1;
        req_addr <= a;
        @(posedge sys_clk);
        #1;
        chk("decode", {17'h0, exp_dec(a)}, {17'h0, sel_reg_q, sel_ram_q, sel_ee_q, sel_flash_q,
            sel_ext_q, ecs_n, xcs_n, stretch, flash_page_q});
    endtask

    task automatic sweep(input int n);
        foreach (corner[k]) probe(corner[k]);
        repeat (n) begin
            rnd = xs(rnd);
            probe(rnd[15:0]);
        end
        @(posedge sys_clk);
        req <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(posedge sys_clk);
        rstn <= 1'b0;
        mode_pins <= m;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        s_mode = m;
        {s_ram, s_reg, s_ee, s_page} = 32'h0000_0000;
        s_misc = 8'h0D;
    endtask

    // ==========================================================
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        final_report();
    end

    // ==========================================================
    // Main sequence: normal, emulation, special single chip, then special test
    initial begin
        {rstn, avs_read, avs_write, req, avs_address, avs_byteenable} = 16'h0000;
        {avs_writedata, req_addr} = 48'h0000_0000_0000;
        mode_pins = 3'b111;
        rnd = 32'h0000_0016;
        do_reset(mmc_pkg::MODE_NORMAL_WIDE);
        rchk("misc_rst", mmc_pkg::IDX_MISC, 8'h0D);
        rchk("size_a", mmc_pkg::IDX_MEMSIZE_A, 8'h10);
        rchk("unmapped", 6'h20, 8'h00);
        wr(mmc_pkg::IDX_RAM_POS, 8'h4F);
        wr(mmc_pkg::IDX_RAM_POS, 8'hB0);
        rchk("ram_pos", mmc_pkg::IDX_RAM_POS, 8'h49);
        wr(mmc_pkg::IDX_REG_POS, 8'hFF);
        wr(mmc_pkg::IDX_REG_POS, 8'h08);
        rchk("reg_pos", mmc_pkg::IDX_REG_POS, 8'h78);
        wr(mmc_pkg::IDX_MISC, 8'hFB);
        wr(mmc_pkg::IDX_MISC, 8'h00);
        rchk("misc", mmc_pkg::IDX_MISC, 8'h0B);
        wr(mmc_pkg::IDX_EE_POS, 8'h91);
        wr(mmc_pkg::IDX_EE_POS, 8'h8F);
        rchk("ee_pos", mmc_pkg::IDX_EE_POS, 8'h89);
        wr(mmc_pkg::IDX_TEST_A, 8'hFF);
        wr(mmc_pkg::IDX_PAGE_RSVD, 8'hFF);
        wr(mmc_pkg::IDX_MEMSIZE_B, 8'hFF);
        rchk("test_a", mmc_pkg::IDX_TEST_A, 8'h00);
        rchk("rsvd", mmc_pkg::IDX_PAGE_RSVD, 8'h00);
        rchk("size_b", mmc_pkg::IDX_MEMSIZE_B, 8'h00);
        repeat (4) begin
            rnd = xs(rnd);
            wr(mmc_pkg::IDX_PAGE, rnd[7:0]);
            rchk("page", mmc_pkg::IDX_PAGE, rnd[7:0] & 8'h3F);
        end
        bus(1'b1, mmc_pkg::IDX_PAGE, ~rnd[7:0], 4'h0);
        rchk("page_be", mmc_pkg::IDX_PAGE, rnd[7:0] & 8'h3F);
        {s_ram, s_reg, s_misc, s_ee, s_page} = {32'h4978_0B89, rnd[7:0] & 8'h3F};
        sweep(40);
        do_reset(mmc_pkg::MODE_EMUL_WIDE);
        sweep(20);
        // Emulation modes keep only the first write after reset
        wr(mmc_pkg::IDX_RAM_POS, 8'h08);
        wr(mmc_pkg::IDX_RAM_POS, 8'h10);
        rchk("ram_emul", mmc_pkg::IDX_RAM_POS, 8'h08);
        wr(mmc_pkg::IDX_MISC, 8'h0C);
        wr(mmc_pkg::IDX_MISC, 8'h01);
        rchk("misc_emul", mmc_pkg::IDX_MISC, 8'h0C);
        do_reset(mmc_pkg::MODE_SPECIAL_SINGLE);
        wr(mmc_pkg::IDX_RAM_POS, 8'h48);
        wr(mmc_pkg::IDX_RAM_POS, 8'h51);
        rchk("ram_any", mmc_pkg::IDX_RAM_POS, 8'h51);
        wr(mmc_pkg::IDX_REG_POS, 8'h10);
        wr(mmc_pkg::IDX_REG_POS, 8'h20);
        rchk("reg_any", mmc_pkg::IDX_REG_POS, 8'h20);
        // Address held across a move of the RAM; decode must lag the write by one edge
        @(posedge sys_clk);
        req <= 1'b1;
        req_addr <= 16'h5000;
        wr(mmc_pkg::IDX_RAM_POS, 8'h50);
        #1;
        chk("ram_sel_old", 32'h0, {31'h0, sel_ram_q});
        @(posedge sys_clk);
        #1;
        chk("ram_sel_new", 32'h1, {31'h0, sel_ram_q});
        {s_ram, s_reg} = 16'h5020;
        sweep(20);
        // Special test mode starts with the flash removed from the map
        do_reset(mmc_pkg::MODE_SPECIAL_TEST);
        rchk("misc_test", mmc_pkg::IDX_MISC, 8'h0C);
        final_report();
    end
endmodule
